//--- hdl/tio_defs.vh
// constants for the three-port tristate i/o block
`ifndef TIO_DEFS_VH
`define TIO_DEFS_VH

// file addresses of the port data registers
`define TIO_ADDR_W 5
`define TIO_ADDR_FIRST 5'h05
`define TIO_ADDR_SECOND 5'h06
`define TIO_ADDR_THIRD 5'h07

// port index codes returned by the address decoder
`define TIO_SEL_NONE 2'h0
`define TIO_SEL_FIRST 2'h1
`define TIO_SEL_SECOND 2'h2
`define TIO_SEL_THIRD 2'h3

// widths
`define TIO_DATA_W 8
`define TIO_FIRST_W 4

// direction register reset value, all pins input
`define TIO_DIR_RESET 8'hff
`define TIO_FIRST_DIR_RESET 4'hf

// value returned for unmapped addresses and unimplemented bits
`define TIO_READ_ZERO 8'h00
`define TIO_FIRST_PAD 4'h0

`endif

//--- hdl/tio_ports.v
// three general purpose tristate i/o ports with write-only direction registers
//
// Overview of operation
// - a data register read returns pin levels, except 07h on the small variant, which returns the output latch
// - direction registers are write-only and reset to all ones
// - first port has four pins; bits 7 to 4 read zero
// - second port has eight bidirectional pins on bits 7 to 0
// - third port has pins on large variants, plain storage otherwise
// - direction-load instruction copies the accumulator into the selected direction register
// - direction one means input, zero drives the output latch onto pin
// - data registers sit at file addresses 05h, 06h, 07h
// - inputs are not latched; pins are sampled through two flops on every clock
// - output latch holds its value until the port is rewritten
// - each pin direction is set independently of the others
`timescale 1ns/1ps
`include "tio_defs.vh"
module tio_ports #(
  parameter HAS_THIRD_PORT = 1, // 1: third port has pins, 0: plain data register
  parameter DATA_W = `TIO_DATA_W, // width of the core data path
  parameter FIRST_W = `TIO_FIRST_W // implemented pins of the first port
) (
  input wire CLK, // core instruction clock
  input wire RST_N, // power-on reset, async, active low
  input wire CORE_RST, // external-pin or watchdog reset, sync, active high
  input wire [4:0] FILE_ADDR, // file register address from the core
  input wire FILE_WE, // write strobe, one cycle
  input wire [7:0] FILE_WDATA, // write data
  input wire FILE_RE, // read strobe, one cycle
  output reg [7:0] FILE_RDATA, // read data, valid the cycle after FILE_RE
  output reg FILE_RHIT, // high with FILE_RDATA when the address was ours
  input wire DIR_LOAD, // direction-load instruction strobe
  input wire [4:0] DIR_SEL, // direction-load operand, a port address
  input wire [7:0] ACC, // accumulator contents
  input wire [3:0] FIRST_PINS_I, // first port pin levels
  output reg [3:0] FIRST_PINS_O, // first port output values
  output reg [3:0] FIRST_PINS_OE, // first port drive enables
  input wire [7:0] SECOND_PINS_I, // second port pin levels
  output reg [7:0] SECOND_PINS_O, // second port output values
  output reg [7:0] SECOND_PINS_OE, // second port drive enables
  input wire [7:0] THIRD_PINS_I, // third port pin levels
  output reg [7:0] THIRD_PINS_O, // third port output values
  output reg [7:0] THIRD_PINS_OE // third port drive enables
);

  // maps a file address to a port index code
  function [1:0] port_decode;
    input [4:0] addr;
    begin
      if (addr == `TIO_ADDR_FIRST) begin
        port_decode = `TIO_SEL_FIRST;
      end else if (addr == `TIO_ADDR_SECOND) begin
        port_decode = `TIO_SEL_SECOND;
      end else if (addr == `TIO_ADDR_THIRD) begin
        port_decode = `TIO_SEL_THIRD;
      end else begin
        port_decode = `TIO_SEL_NONE;
      end
    end
  endfunction

  // pin drive value: zero while the pin is an input, latch bit otherwise
  function [7:0] drive_value;
    input [7:0] latch;
    input [7:0] dir;
    begin
      drive_value = latch & ~dir;
    end
  endfunction

  // first port has only four pins, so its drive value is a nibble
  function [3:0] drive_nibble;
    input [3:0] latch;
    input [3:0] dir;
    begin
      drive_nibble = latch & ~dir;
    end
  endfunction

  // output latches carry no reset so power-on leaves them unknown
  reg [3:0] first_latch_ff;
  reg [7:0] second_latch_ff;
  reg [7:0] third_latch_ff;

  // direction registers, write-only from the core
  reg [3:0] first_dir_ff;
  reg [7:0] second_dir_ff;
  reg [7:0] third_dir_ff;

  reg [3:0] nxt_first_latch;
  reg [7:0] nxt_second_latch;
  reg [7:0] nxt_third_latch;
  reg [3:0] nxt_first_dir;
  reg [7:0] nxt_second_dir;
  reg [7:0] nxt_third_dir;
  reg [7:0] nxt_rdata;
  reg nxt_rhit;

  wire [1:0] wr_sel;
  wire [1:0] rd_sel;
  wire [1:0] dir_sel;
  wire [3:0] first_pins_s;
  wire [7:0] second_pins_s;
  wire [7:0] third_pins_s;

  // one-hot strobes, one per port, for writes, reads and direction loads
  wire wr_first;
  wire wr_second;
  wire wr_third;
  wire rd_first;
  wire rd_second;
  wire rd_third;
  wire ld_first;
  wire ld_second;
  wire ld_third;

  // read values per port, built from synchronised pins, or from the latch at 07h on the small variant
  wire [7:0] first_rd_val;
  wire [7:0] second_rd_val;
  wire [7:0] third_rd_val;

  // next values of the registered pin outputs
  reg [3:0] nxt_first_o;
  reg [3:0] nxt_first_oe;
  reg [7:0] nxt_second_o;
  reg [7:0] nxt_second_oe;
  reg [7:0] nxt_third_o;
  reg [7:0] nxt_third_oe;

  // address decode for writes, reads and direction operands
  assign wr_sel = port_decode(FILE_ADDR);
  assign rd_sel = port_decode(FILE_ADDR);
  assign dir_sel = port_decode(DIR_SEL);

  // an unmapped address raises no strobe, so such writes vanish silently
  assign wr_first = FILE_WE && (wr_sel == `TIO_SEL_FIRST);
  assign wr_second = FILE_WE && (wr_sel == `TIO_SEL_SECOND);
  assign wr_third = FILE_WE && (wr_sel == `TIO_SEL_THIRD);

  // read strobes; an unmapped read answers zero with no hit
  assign rd_first = FILE_RE && (rd_sel == `TIO_SEL_FIRST);
  assign rd_second = FILE_RE && (rd_sel == `TIO_SEL_SECOND);
  assign rd_third = FILE_RE && (rd_sel == `TIO_SEL_THIRD);

  // direction operands other than the three port addresses are ignored
  assign ld_first = DIR_LOAD && (dir_sel == `TIO_SEL_FIRST);
  assign ld_second = DIR_LOAD && (dir_sel == `TIO_SEL_SECOND);
  assign ld_third = DIR_LOAD && (dir_sel == `TIO_SEL_THIRD);

  // reads see pins, not latches, except at 07h on the small variant, which has no pins and reads its latch
  assign first_rd_val = {`TIO_FIRST_PAD, first_pins_s};
  assign second_rd_val = second_pins_s;
  assign third_rd_val = (HAS_THIRD_PORT != 0) ? third_pins_s : third_latch_ff;

  // pins come from outside the clock domain, so two flops before any use
  tio_sync2 #(
    .WIDTH(FIRST_W)
  ) u_sync_first (
    .CLK(CLK),
    .RST_N(RST_N),
    .async_in(FIRST_PINS_I),
    .sync_out(first_pins_s)
  );

  // second port, eight pins
  tio_sync2 #(
    .WIDTH(DATA_W)
  ) u_sync_second (
    .CLK(CLK),
    .RST_N(RST_N),
    .async_in(SECOND_PINS_I),
    .sync_out(second_pins_s)
  );

  // third port pins, left unread on the small variant
  tio_sync2 #(
    .WIDTH(DATA_W)
  ) u_sync_third (
    .CLK(CLK),
    .RST_N(RST_N),
    .async_in(THIRD_PINS_I),
    .sync_out(third_pins_s)
  );

  // latch next values; a write lands whatever the direction says
  always @* begin
    nxt_first_latch = first_latch_ff;
    nxt_second_latch = second_latch_ff;
    nxt_third_latch = third_latch_ff;
    if (wr_first) begin
      nxt_first_latch = FILE_WDATA[3:0];
    end
    if (wr_second) begin
      nxt_second_latch = FILE_WDATA;
    end
    if (wr_third) begin
      nxt_third_latch = FILE_WDATA;
    end
  end

  // core reset leaves the latches alone, only a write changes them
  // no reset branch at all, so a fresh power-on leaves them unknown
  always @(posedge CLK) begin
    first_latch_ff <= nxt_first_latch;
    second_latch_ff <= nxt_second_latch;
    third_latch_ff <= nxt_third_latch;
  end

  // direction next values from the direction-load instruction
  // core reset wins over a load arriving in the same cycle
  always @* begin
    nxt_first_dir = first_dir_ff;
    nxt_second_dir = second_dir_ff;
    nxt_third_dir = third_dir_ff;
    if (CORE_RST) begin
      nxt_first_dir = `TIO_FIRST_DIR_RESET;
      nxt_second_dir = `TIO_DIR_RESET;
      nxt_third_dir = `TIO_DIR_RESET;
    end else begin
      if (ld_first) begin
        nxt_first_dir = ACC[3:0];
      end
      if (ld_second) begin
        nxt_second_dir = ACC;
      end
      if (ld_third) begin
        nxt_third_dir = ACC;
      end
    end
  end

  // power-on reset forces every pin to input
  // core reset reaches the same value through the next-value logic
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_dir_ff <= `TIO_FIRST_DIR_RESET;
      second_dir_ff <= `TIO_DIR_RESET;
      third_dir_ff <= `TIO_DIR_RESET;
    end else begin
      first_dir_ff <= nxt_first_dir;
      second_dir_ff <= nxt_second_dir;
      third_dir_ff <= nxt_third_dir;
    end
  end

  // read mux: pins, or the 07h latch on the small variant; direction registers have no address
  always @* begin
    nxt_rdata = `TIO_READ_ZERO;
    nxt_rhit = 1'b0;
    if (FILE_RE) begin
      if (rd_first) begin
        nxt_rdata = first_rd_val;
        nxt_rhit = 1'b1;
      end else if (rd_second) begin
        nxt_rdata = second_rd_val;
        nxt_rhit = 1'b1;
      end else if (rd_third) begin
        nxt_rdata = third_rd_val;
        nxt_rhit = 1'b1;
      end
    end
  end

  // read data held until the next read strobe so the core may sample late
  // pins reach it three edges late: two synchroniser flops, then this register
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FILE_RDATA <= `TIO_READ_ZERO;
      FILE_RHIT <= 1'b0;
    end else if (FILE_RE) begin
      FILE_RDATA <= nxt_rdata;
      FILE_RHIT <= nxt_rhit;
    end
  end

  // drive values; an input pin shows zero so power-on unknowns stay inside
  always @* begin
    nxt_first_o = drive_nibble(first_latch_ff, first_dir_ff);
    nxt_first_oe = ~first_dir_ff;
    nxt_second_o = drive_value(second_latch_ff, second_dir_ff);
    nxt_second_oe = ~second_dir_ff;
    nxt_third_o = 8'h00;
    nxt_third_oe = 8'h00;
    if (HAS_THIRD_PORT != 0) begin
      nxt_third_o = drive_value(third_latch_ff, third_dir_ff);
      nxt_third_oe = ~third_dir_ff;
    end
  end

  // pin drivers registered so every output leaves the block from a flop
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIRST_PINS_O <= 4'h0;
      FIRST_PINS_OE <= 4'h0;
      SECOND_PINS_O <= 8'h00;
      SECOND_PINS_OE <= 8'h00;
      THIRD_PINS_O <= 8'h00;
      THIRD_PINS_OE <= 8'h00;
    end else begin
      FIRST_PINS_O <= nxt_first_o;
      FIRST_PINS_OE <= nxt_first_oe;
      SECOND_PINS_O <= nxt_second_o;
      SECOND_PINS_OE <= nxt_second_oe;
      THIRD_PINS_O <= nxt_third_o;
      THIRD_PINS_OE <= nxt_third_oe;
    end
  end

endmodule

//--- hdl/tio_sync2.v
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module tio_sync2 #(
  parameter WIDTH = 8
) (
  input wire CLK, // core clock
  input wire RST_N, // async reset, active low
  input wire [WIDTH-1:0] async_in, // raw pin levels
  output wire [WIDTH-1:0] sync_out // levels safe to use in the clock domain
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

//--- tb/tio_pins_model.sv
// far-side circuitry of one port: senses driven pins, drives the rest
`timescale 1ns/1ps
module tio_pins_model (
  input wire [7:0] oe, // device drive enables
  input wire [7:0] o, // device output values
  input wire [7:0] ext, // level the far side applies
  input wire [7:0] ovr, // far side overpowers a driven pin
  output wire [7:0] pin // resolved pin level
);
  // a weak far side loses to the driver, a strong one wins the pin
  wire [7:0] dev = oe & ~ovr;
  assign pin = (dev & o) | (~dev & ext);
endmodule

//--- tb/tio_ports_bench.sv
// self-checking bench for the three-port tristate i/o block
`timescale 1ns/1ps
module tio_ports_bench;
  logic CLK = 0, RST_N = 0, CORE_RST = 0, FILE_WE = 0, FILE_RE = 0, DIR_LOAD = 0;
  logic [4:0] FILE_ADDR = 0, DIR_SEL = 0;
  logic [7:0] FILE_WDATA = 0, ACC = 0;
  logic [7:0] ext [3] = '{0, 0, 0}, ovr [3] = '{0, 0, 0}, dat [3], dir [3];
  wire [7:0] o [3], oe [3], pin [3], FILE_RDATA;
  wire FILE_RHIT;
  wire [7:0] s_rdata, s_o3, s_oe3;
  wire s_rhit;
  int fails = 0, n_tests = 0;
  always #20 CLK = ~CLK;
  tio_ports dut (.CLK(CLK), .RST_N(RST_N), .CORE_RST(CORE_RST), .FILE_ADDR(FILE_ADDR), .FILE_WE(FILE_WE),
    .FILE_WDATA(FILE_WDATA), .FILE_RE(FILE_RE), .FILE_RDATA(FILE_RDATA), .FILE_RHIT(FILE_RHIT),
    .DIR_LOAD(DIR_LOAD), .DIR_SEL(DIR_SEL), .ACC(ACC), .FIRST_PINS_I(pin[0][3:0]), .FIRST_PINS_O(o[0][3:0]),
    .FIRST_PINS_OE(oe[0][3:0]), .SECOND_PINS_I(pin[1]), .SECOND_PINS_O(o[1]), .SECOND_PINS_OE(oe[1]),
    .THIRD_PINS_I(pin[2]), .THIRD_PINS_O(o[2]), .THIRD_PINS_OE(oe[2]));
  assign o[0][7:4] = 4'h0;
  assign oe[0][7:4] = 4'h0;
  // small variant on the same bus: third location is plain storage
  tio_ports #(.HAS_THIRD_PORT(0)) dut_s (.CLK(CLK), .RST_N(RST_N), .CORE_RST(CORE_RST), .FILE_ADDR(FILE_ADDR),
    .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .FILE_RE(FILE_RE), .FILE_RDATA(s_rdata), .FILE_RHIT(s_rhit),
    .DIR_LOAD(DIR_LOAD), .DIR_SEL(DIR_SEL), .ACC(ACC), .FIRST_PINS_I(pin[0][3:0]), .FIRST_PINS_O(),
    .FIRST_PINS_OE(), .SECOND_PINS_I(pin[1]), .SECOND_PINS_O(), .SECOND_PINS_OE(), .THIRD_PINS_I(pin[2]),
    .THIRD_PINS_O(s_o3), .THIRD_PINS_OE(s_oe3));
  tio_pins_model m0 (.oe(oe[0]), .o(o[0]), .ext(ext[0]), .ovr(ovr[0]), .pin(pin[0]));
  tio_pins_model m1 (.oe(oe[1]), .o(o[1]), .ext(ext[1]), .ovr(ovr[1]), .pin(pin[1]));
  tio_pins_model m2 (.oe(oe[2]), .o(o[2]), .ext(ext[2]), .ovr(ovr[2]), .pin(pin[2]));
  // expected pin level; first port has only four pins
  function automatic logic [7:0] lvl(int p);
    logic [7:0] d;
    d = ~dir[p] & ~ovr[p];
    return ((d & dat[p]) | (~d & ext[p])) & (p ? 8'hff : 8'h0f);
  endfunction
  task automatic chk(logic [8:0] seen, logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // one write or direction load, strobe held for one edge
  task automatic op(logic ld, logic [4:0] a, logic [7:0] d);
    @(posedge CLK);
    {DIR_LOAD, FILE_WE, DIR_SEL, FILE_ADDR, ACC, FILE_WDATA} <= {ld, !ld, a, a, d, d};
    @(posedge CLK);
    {DIR_LOAD, FILE_WE} <= '0;
  endtask
  task automatic rd(logic [4:0] a, logic [8:0] e);
    @(posedge CLK);
    {FILE_RE, FILE_ADDR} <= {1'b1, a};
    @(posedge CLK);
    FILE_RE <= 0;
    #1 chk({FILE_RHIT, FILE_RDATA}, e);
  endtask
  task automatic end_sim;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hf851_df8a));
    repeat (10) @(posedge CLK);
    RST_N <= 1;
    tick(2);
    for (int p = 0; p < 3; p++) chk(oe[p], 0);
    // latch written first, then direction, so writes to inputs are covered
    for (int i = 0; i < 24; i++) begin
      for (int p = 0; p < 3; p++) begin
        dat[p] = $urandom;
        dir[p] = i == 0 ? 8'h00 : i == 1 ? 8'hff : $urandom;
        op(0, 5'h05 + 5'(p), dat[p]);
        op(1, 5'h05 + 5'(p), dir[p]);
        ext[p] <= $urandom;
        ovr[p] <= p == 1 ? $urandom & $urandom : 0;
      end
      // far side holds its levels until the reads are done
      tick(4);
      for (int p = 0; p < 3; p++) begin
        chk(oe[p], ~dir[p] & (p ? 8'hff : 8'h0f));
        chk(o[p], dat[p] & ~dir[p] & (p ? 8'hff : 8'h0f));
        rd(5'h05 + 5'(p), {1'b1, lvl(p)});
      end
      // small variant: last read was 07h, which there returns the latch
      chk({s_rhit, s_rdata}, {1'b1, dat[2]});
      chk(s_oe3, 0);
      chk(s_o3, 0);
    end
    // soft reset drops drivers but keeps the latches
    @(posedge CLK) CORE_RST <= 1;
    @(posedge CLK) CORE_RST <= 0;
    tick(2);
    for (int p = 0; p < 3; p++) chk(oe[p], 0);
    op(1, 5'h06, 8'h00);
    op(1, 5'h10, 8'hff);
    tick(2);
    chk(oe[1], 8'hff);
    chk(o[1], dat[1]);
    rd(5'h04, 0);
    rd(5'h08, 0);
    end_sim;
  end
  // watchdog: about 600 cycles expected, 5000 allowed
  initial begin
    #200000;
    fails++;
    end_sim;
  end
endmodule

//--- tb/tio_ports_properties.sv
// port-level assertions for the three-port tristate i/o block
`timescale 1ns/1ps
module tio_ports_properties (
  input wire CLK, // clock
  input wire RST_N, // reset
  input wire CORE_RST, // soft reset
  input wire [4:0] FILE_ADDR, // address
  input wire FILE_WE, // write
  input wire [7:0] FILE_WDATA, // wdata
  input wire FILE_RE, // read
  input wire [7:0] FILE_RDATA, // rdata
  input wire FILE_RHIT, // hit
  input wire DIR_LOAD, // dir load
  input wire [4:0] DIR_SEL, // operand
  input wire [7:0] ACC, // acc
  input wire [3:0] FIRST_PINS_OE, // drives
  input wire [7:0] SECOND_PINS_I, // pins
  input wire [7:0] SECOND_PINS_O, // outputs
  input wire [7:0] SECOND_PINS_OE, // drives
  input wire [7:0] THIRD_PINS_OE // drives
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // soft reset wins over a load in the same cycle
  wire ld = DIR_LOAD && !CORE_RST;
  property p_rst; CORE_RST |-> ##2 {FIRST_PINS_OE, SECOND_PINS_OE, THIRD_PINS_OE} == 0; endproperty
  a_rst: assert property (p_rst) else $error("drivers on after soft reset");
  property p_ld1; ld && DIR_SEL == 5'h05 |-> ##2 FIRST_PINS_OE == 4'(~$past(ACC, 2)); endproperty
  a_ld1: assert property (p_ld1) else $error("first drive mismatch");
  property p_ld2; ld && DIR_SEL == 5'h06 |-> ##2 SECOND_PINS_OE == ~$past(ACC, 2); endproperty
  a_ld2: assert property (p_ld2) else $error("second drive mismatch");
  property p_drv; (SECOND_PINS_O & ~SECOND_PINS_OE) == 0; endproperty
  a_drv: assert property (p_drv) else $error("output on an input pin");
  property p_wr; FILE_WE && FILE_ADDR == 5'h06 |-> ##2 SECOND_PINS_O == ($past(FILE_WDATA, 2) & SECOND_PINS_OE); endproperty
  a_wr: assert property (p_wr) else $error("latch not on pins");
  property p_miss; FILE_RE && (FILE_ADDR < 5'h05 || FILE_ADDR > 5'h07) |=> FILE_RDATA == 0 && !FILE_RHIT; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read answered");
  property p_hit1; FILE_RE && FILE_ADDR == 5'h05 |=> FILE_RHIT && FILE_RDATA[7:4] == 0; endproperty
  a_hit1: assert property (p_hit1) else $error("first port upper bits set");
  property p_rd; FILE_RE && FILE_ADDR == 5'h06 && $stable(SECOND_PINS_I) && $past(SECOND_PINS_I, 2) == SECOND_PINS_I
    && $past(SECOND_PINS_I, 3) == SECOND_PINS_I && $past(RST_N, 1) && $past(RST_N, 2) && $past(RST_N, 3)
    |=> FILE_RDATA == $past(SECOND_PINS_I); endproperty
  a_rd: assert property (p_rd) else $error("read is not pin level");
endmodule
bind tio_ports tio_ports_properties u_chk (.CLK(CLK), .RST_N(RST_N), .CORE_RST(CORE_RST), .FILE_ADDR(FILE_ADDR),
  .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .FILE_RE(FILE_RE), .FILE_RDATA(FILE_RDATA), .FILE_RHIT(FILE_RHIT),
  .DIR_LOAD(DIR_LOAD), .DIR_SEL(DIR_SEL), .ACC(ACC), .FIRST_PINS_OE(FIRST_PINS_OE), .SECOND_PINS_I(SECOND_PINS_I),
  .SECOND_PINS_O(SECOND_PINS_O), .SECOND_PINS_OE(SECOND_PINS_OE), .THIRD_PINS_OE(THIRD_PINS_OE));
